// File: src/rpc_consts.svh
// Register offsets, field positions, reset values and timing counts of the payload control stage.
`ifndef RPC_CONSTS_SVH
`define RPC_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices; the byte address is four times the index
// ----------------------------------------------------------------
`define RPC_IDX_W 10
`define RPC_IDX_CONFIG 10'h050
`define RPC_IDX_STATUS 10'h051
`define RPC_IDX_ADDRCTL 10'h052
`define RPC_IDX_DATABUF 10'h053
`define RPC_IDX_AUX 10'h05F
`define RPC_PADDR_W 12

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define RPC_RST_BYTE 8'h00
`define RPC_CONFIG_MASK 8'h01
`define RPC_AUX_MASK 8'h03
`define RPC_SIGTRK_MASK 8'h8F

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RPC_CFG_PER_CHANNEL_FUNCTIONS_ENABLE 0
`define RPC_STAT_BUSY 7
`define RPC_AC_RNW 7
`define RPC_AUX_GEN 0
`define RPC_AUX_FRAC 1
`define RPC_CC_INVERT 7
`define RPC_CC_TRUNK 6
`define RPC_CC_MW 5
`define RPC_CC_MSBINV 4
`define RPC_CC_TEST 3
`define RPC_CC_EXTRACT 2
`define RPC_CC_FIX 1
`define RPC_CC_LEVEL 0
`define RPC_ST_ENABLE 7

// ----------------------------------------------------------------
// Indirect space
// ----------------------------------------------------------------
`define RPC_IA_FIRST 7'h01
`define RPC_IA_LAST 7'h48
`define RPC_NCHAN 24
`define RPC_NENTRY 72
`define RPC_LAST_CHAN 5'd23

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RPC_CLK_PERIOD_NS 5
`define RPC_ACCESS_NS 640
`define RPC_ACCESS_CYC (`RPC_ACCESS_NS / `RPC_CLK_PERIOD_NS)
`define RPC_HS_DIV 2

// ----------------------------------------------------------------
// Companded milliwatt tone, eight bytes, first byte in the top bits
// ----------------------------------------------------------------
`define RPC_MW_SEQ 64'h1E0B0B1E9E8B8B9E

`endif

// File: src/rpc_ind_mem.sv
// Indirect register storage: per-channel configuration, data trunk codes and signaling trunk bytes.
`timescale 1ns/1ps
`default_nettype none
`include "rpc_consts.svh"
module rpc_ind_mem #(
  parameter int NCHAN = `RPC_NCHAN
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Access port, indirect address 01H upward
  input wire logic wrEn,
  input wire logic [6:0] addr,
  input wire logic [7:0] wrData,
  output logic [7:0] rdData,
  // Channel port
  input wire logic [4:0] chan,
  output logic [7:0] chanCfg,
  output logic [7:0] chanTrunk,
  output logic [7:0] chanSigTrunk
);

  localparam int NENT = 3 * NCHAN;

  typedef struct packed {
    logic [NENT-1:0][7:0] entry;
  } rpc_mem_state_t;

  rpc_mem_state_t s;
  rpc_mem_state_t next_s;
  logic [6:0] entIdx;

  assign entIdx = addr - `RPC_IA_FIRST;

  // Signaling trunk bytes keep their reserved bits at zero.
  always_comb begin
    next_s = s;
    for (int i = 0; i < NENT; i++) begin
      if (wrEn && entIdx == 7'(i)) begin
        next_s.entry[i] = (i >= 2 * NCHAN) ? (wrData & `RPC_SIGTRK_MASK) : wrData;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rdData = (entIdx < 7'(NENT)) ? s.entry[entIdx] : `RPC_RST_BYTE;
  assign chanCfg = s.entry[chan];
  assign chanTrunk = s.entry[7'(chan) + 7'(NCHAN)];
  assign chanSigTrunk = s.entry[7'(chan) + 7'(2 * NCHAN)];

endmodule
`default_nettype wire

// File: src/rpc_payload_ctrl.sv
// Receive payload control stage: per-channel data and signaling processing with indirect registers on APB.
//
// Overview of operation
// - Enable bit zero bypasses all channel processing.
// - Busy reads one while indirect access pending.
// - Access lasts 640 ns; busy clears on tick.
// - Valid address/control write starts one access.
// - Direction zero writes buffer, one reads register.
// - Seven-bit address selects 01H through 48H.
// - Read data sits in buffer within 640 ns.
// - Config, trunk codes, signaling trunk in three banks.
// - Invert and MSB select choose inversion pattern.
// - Trunk enable substitutes channel trunk code byte.
// - Milliwatt enable substitutes digital milliwatt pattern.
// - Test bit extracts or inserts pattern per direction.
// - Test channels form one continuous pattern stream.
// - Fractional mode clocks only extract-enabled channels.
// - Fix bit forces signaling bit to level.
// - Extract, trunk, milliwatt, pattern, invert, fix priority.
// - Signaling trunk enable substitutes A, B, C, D.
// - Substituted nibble occupies signaling low nibble.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "rpc_consts.svh"
module rpc_payload_ctrl #(
  parameter int ACCESS_CYC = `RPC_ACCESS_CYC,
  parameter int HS_DIV = `RPC_HS_DIV,
  parameter int NCHAN = `RPC_NCHAN
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // APB slave
  input wire rpc_pkg::rpc_apb_req_t apbReq,
  output rpc_pkg::rpc_apb_rsp_t apbRsp,
  // Received stream from the framer
  input wire rpc_pkg::rpc_rx_t rxIn,
  // Processed stream to the system side
  output rpc_pkg::rpc_tx_t txOut,
  // Pattern generator and detector
  output rpc_pkg::rpc_pattern_gen_detector_t prgdOut,
  input wire logic prgdGenData
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] configReg;
    logic [7:0] auxReg;
    logic [7:0] addrCtl;
    logic [7:0] dataBuf;
    rpc_pkg::rpc_acc_state_t acc;
    logic [7:0] accCnt;
    logic [31:0] prdata;
    logic pslverr;
    logic inPayload;
    logic [4:0] chan;
    logic [2:0] bitPos;
    logic [2:0] mwPhase;
    rpc_pkg::rpc_tx_t tx;
    logic extValid;
    logic extData;
  } rpc_main_state_t;

  rpc_main_state_t s;
  rpc_main_state_t next_s;

  logic hsTick;
  logic memWr;
  logic [7:0] memRd;
  logic [7:0] chanCfg;
  logic [7:0] chanTrunk;
  logic [7:0] chanSigTrunk;
  logic genReq;

  // ----------------------------------------------------------------
  // Internal high-speed clock and indirect storage
  // ----------------------------------------------------------------
  rpc_tick_div #(
    .DIV(HS_DIV)
  ) u_div (
    .mclk(mclk),
    .resetn(resetn),
    .tick(hsTick)
  );

  rpc_ind_mem #(
    .NCHAN(NCHAN)
  ) u_mem (
    .mclk(mclk),
    .resetn(resetn),
    .wrEn(memWr),
    .addr(s.addrCtl[6:0]),
    .wrData(s.dataBuf),
    .rdData(memRd),
    .chan(s.chan),
    .chanCfg(chanCfg),
    .chanTrunk(chanTrunk),
    .chanSigTrunk(chanSigTrunk)
  );

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  logic apbSetup;
  logic apbAccess;
  logic [9:0] regIdx;
  logic mapped;
  logic busy;
  logic [7:0] rdByte;
  logic per_channel_functions_enable;
  logic genMode;
  logic fracMode;
  logic payloadBit;
  logic [2:0] codeBit;

  assign apbSetup = apbReq.psel && !apbReq.penable;
  assign apbAccess = apbReq.psel && apbReq.penable;
  assign regIdx = apbReq.paddr[11:2];
  assign busy = (s.acc != rpc_pkg::ACC_IDLE);
  assign per_channel_functions_enable = s.configReg[`RPC_CFG_PER_CHANNEL_FUNCTIONS_ENABLE];
  assign genMode = s.auxReg[`RPC_AUX_GEN];
  assign fracMode = s.auxReg[`RPC_AUX_FRAC];
  assign payloadBit = rxIn.bitEn && !rxIn.frameStart && s.inPayload;
  assign codeBit = 3'd7 - s.bitPos;

  // The tone sits in a vector, since a literal cannot be bit-selected.
  localparam logic [63:0] MW_SEQ = `RPC_MW_SEQ;
  logic [5:0] mwIdx;
  logic mwBit;
  assign mwIdx = 6'd63 - {s.mwPhase, s.bitPos};
  assign mwBit = MW_SEQ[mwIdx];

  // ----------------------------------------------------------------
  // Per-channel operation selects
  // ----------------------------------------------------------------
  logic selExtract;
  logic selTrunk;
  logic selMw;
  logic selGen;
  logic selInvert;
  logic selFix;

  assign selExtract = chanCfg[`RPC_CC_TEST] && !genMode;
  assign selTrunk = chanCfg[`RPC_CC_TRUNK];
  assign selMw = chanCfg[`RPC_CC_MW];
  assign selGen = chanCfg[`RPC_CC_TEST] && genMode;
  assign selInvert = chanCfg[`RPC_CC_INVERT] || chanCfg[`RPC_CC_MSBINV];
  assign selFix = chanCfg[`RPC_CC_FIX] && rxIn.sigFrame && s.bitPos == 3'd7;

  always_comb begin
    mapped = 1'b1;
    rdByte = `RPC_RST_BYTE;
    unique case (regIdx)
      `RPC_IDX_CONFIG: begin
        rdByte = s.configReg;
      end
      `RPC_IDX_STATUS: begin
        rdByte = {busy, 7'h00};
      end
      `RPC_IDX_ADDRCTL: begin
        rdByte = s.addrCtl;
      end
      `RPC_IDX_DATABUF: begin
        rdByte = s.dataBuf;
      end
      `RPC_IDX_AUX: begin
        rdByte = s.auxReg;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
    if (apbReq.paddr[1:0] != 2'b00) begin
      mapped = 1'b0;
    end
  end

  // The generator advances only on bits that it really fills, so the
  // selected channels read as one unbroken sequence.
  assign genReq = payloadBit && per_channel_functions_enable && selGen && !selTrunk && !selMw;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    memWr = 1'b0;
    next_s.tx = '0;
    next_s.extValid = 1'b0;
    next_s.extData = 1'b0;

    // Register read data is latched in the setup phase.
    if (apbSetup) begin
      next_s.prdata = {24'h000000, rdByte};
      next_s.pslverr = !mapped;
    end

    if (apbAccess && apbReq.pwrite && mapped) begin
      unique case (regIdx)
        `RPC_IDX_CONFIG: begin
          next_s.configReg = apbReq.pwdata[7:0] & `RPC_CONFIG_MASK;
        end
        `RPC_IDX_AUX: begin
          next_s.auxReg = apbReq.pwdata[7:0] & `RPC_AUX_MASK;
        end
        `RPC_IDX_ADDRCTL: begin
          // A write while busy is dropped whole.
          if (!busy) begin
            next_s.addrCtl = apbReq.pwdata[7:0];
            if (apbReq.pwdata[6:0] >= `RPC_IA_FIRST && apbReq.pwdata[6:0] <= `RPC_IA_LAST) begin
              next_s.acc = rpc_pkg::ACC_RUN;
              next_s.accCnt = 8'h00;
            end
          end
        end
        `RPC_IDX_DATABUF: begin
          if (!busy) begin
            next_s.dataBuf = apbReq.pwdata[7:0];
          end
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Indirect access engine
    // ----------------------------------------------------------------
    unique case (s.acc)
      rpc_pkg::ACC_IDLE: begin
      end
      rpc_pkg::ACC_RUN: begin
        next_s.accCnt = s.accCnt + 8'h01;
        if (s.accCnt == 8'(ACCESS_CYC - 1)) begin
          if (s.addrCtl[`RPC_AC_RNW]) begin
            next_s.dataBuf = memRd;
          end else begin
            memWr = 1'b1;
          end
          next_s.acc = rpc_pkg::ACC_HOLD;
        end
      end
      rpc_pkg::ACC_HOLD: begin
        if (hsTick) begin
          next_s.acc = rpc_pkg::ACC_IDLE;
        end
      end
      // The fourth code is never entered; should it appear, the engine falls back to idle.
      default: begin
        next_s.acc = rpc_pkg::ACC_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // Channel stream
    // ----------------------------------------------------------------
    if (rxIn.bitEn) begin
      next_s.tx.bitEn = 1'b1;
      next_s.tx.frameStart = rxIn.frameStart;
      next_s.tx.data = rxIn.data;
      next_s.tx.sig = rxIn.sig;
      next_s.tx.sclk = !fracMode;
      if (rxIn.frameStart) begin
        next_s.inPayload = 1'b1;
        next_s.chan = 5'd0;
        next_s.bitPos = 3'd0;
        next_s.mwPhase = s.mwPhase + 3'd1;
      end else if (s.inPayload) begin
        // Without the enable every payload bit is clocked, whatever the mode.
        next_s.tx.sclk = 1'b1;
        if (per_channel_functions_enable) begin
          if (fracMode) begin
            next_s.tx.sclk = chanCfg[`RPC_CC_EXTRACT];
          end
          if (selExtract) begin
            next_s.extValid = 1'b1;
            next_s.extData = rxIn.data;
          end else if (selTrunk) begin
            next_s.tx.data = chanTrunk[codeBit];
          end else if (selMw) begin
            next_s.tx.data = mwBit;
          end else if (selGen) begin
            next_s.tx.data = prgdGenData;
          end else if (selInvert) begin
            unique case ({chanCfg[`RPC_CC_INVERT], chanCfg[`RPC_CC_MSBINV]})
              2'b01: begin
                next_s.tx.data = rxIn.data ^ (s.bitPos == 3'd0);
              end
              2'b10: begin
                next_s.tx.data = !rxIn.data;
              end
              default: begin
                next_s.tx.data = rxIn.data ^ (s.bitPos != 3'd0);
              end
            endcase
          end else if (selFix) begin
            next_s.tx.data = chanCfg[`RPC_CC_LEVEL];
          end
          if (chanSigTrunk[`RPC_ST_ENABLE] && s.bitPos[2]) begin
            next_s.tx.sig = chanSigTrunk[codeBit];
          end
        end
        next_s.bitPos = s.bitPos + 3'd1;
        if (s.bitPos == 3'd7) begin
          next_s.chan = s.chan + 5'd1;
          if (s.chan == 5'(NCHAN - 1)) begin
            next_s.inPayload = 1'b0;
            next_s.chan = 5'd0;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    apbRsp.prdata = s.prdata;
    apbRsp.pslverr = s.pslverr && apbAccess;
    apbRsp.pready = 1'b1;
    txOut = s.tx;
    prgdOut.extValid = s.extValid;
    prgdOut.extData = s.extData;
    prgdOut.genReq = genReq;
  end

endmodule
`default_nettype wire

// File: src/rpc_pkg.sv
// Types shared by the payload control stage.
package rpc_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rpc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rpc_apb_rsp_t;

  typedef struct packed {
    logic bitEn;
    logic frameStart;
    logic sigFrame;
    logic data;
    logic sig;
  } rpc_rx_t;

  typedef struct packed {
    logic bitEn;
    logic frameStart;
    logic data;
    logic sig;
    logic sclk;
  } rpc_tx_t;

  typedef struct packed {
    logic extValid;
    logic extData;
    logic genReq;
  } rpc_pattern_gen_detector_t;

  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_RUN,
    ACC_HOLD
  } rpc_acc_state_t;

endpackage

// File: src/rpc_tick_div.sv
// Divider that makes the internal high-speed clock as an enable pulse.
`timescale 1ns/1ps
`default_nettype none
`include "rpc_consts.svh"
module rpc_tick_div #(
  parameter int DIV = `RPC_HS_DIV
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Enable pulse
  output logic tick
);

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } rpc_div_state_t;

  rpc_div_state_t s;
  rpc_div_state_t next_s;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (s.cnt == 8'(DIV - 1)) begin
      next_s.cnt = 8'h00;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule
`default_nettype wire

// File: test/rpc_pattern_gen_detector_model.sv
// Pattern generator and detector model facing the payload control stage.
`timescale 1ns/1ps
`default_nettype none
module rpc_pattern_gen_detector_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Stage side
  input wire rpc_pkg::rpc_pattern_gen_detector_t prgdOut,
  output logic prgdGenData,
  output logic [15:0] extWord
);
  logic phase;
  // Alternating pattern, advanced only by requests, so test channels join into one stream.
  assign prgdGenData = ~phase;
  always @(posedge mclk) begin
    if (!resetn) begin
      phase <= 1'b0;
      extWord <= 16'h0000;
    end else begin
      if (prgdOut.genReq) phase <= ~phase;
      if (prgdOut.extValid) extWord <= {extWord[14:0], prgdOut.extData};
    end
  end
endmodule
`default_nettype wire

// File: test/rpc_payload_ctrl_assertions.sv
// Concurrent checks on the ports of the payload control stage.
`timescale 1ns/1ps
`default_nettype none
module rpc_payload_ctrl_checker #(
  parameter int ACCESS_CYC = 128,
  parameter int HS_DIV = 2
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Ports of the stage
  input wire rpc_pkg::rpc_apb_req_t apbReq,
  input wire rpc_pkg::rpc_apb_rsp_t apbRsp,
  input wire rpc_pkg::rpc_rx_t rxIn,
  input wire rpc_pkg::rpc_tx_t txOut,
  input wire rpc_pkg::rpc_pattern_gen_detector_t prgdOut,
  input wire logic prgdGenData
);
  logic enableSeen;
  logic fracSeen;
  int runCnt;
  logic wrEdge;
  logic rdStat;
  assign wrEdge = apbReq.psel && apbReq.penable && apbReq.pwrite;
  assign rdStat = apbReq.psel && !apbReq.penable && !apbReq.pwrite && apbReq.paddr == 12'h144;
  // Mirrors the enable and fractional bits and times each indirect access from its start.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      enableSeen <= 1'b0;
      fracSeen <= 1'b0;
      runCnt <= 0;
    end else begin
      if (wrEdge && apbReq.paddr == 12'h140) enableSeen <= apbReq.pwdata[0];
      if (wrEdge && apbReq.paddr == 12'h17C) fracSeen <= apbReq.pwdata[1];
      if (runCnt != 0) runCnt <= (runCnt == ACCESS_CYC + HS_DIV + 1) ? 0 : runCnt + 1;
      else if (wrEdge && apbReq.paddr == 12'h148 && apbReq.pwdata[6:0] inside {[7'h01:7'h48]}) runCnt <= 1;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_bypass_data: assert property (!enableSeen && rxIn.bitEn |=> txOut.data == $past(rxIn.data))
    else $error("data altered while disabled");
  a_bypass_sig: assert property (!enableSeen && rxIn.bitEn |=> txOut.sig == $past(rxIn.sig))
    else $error("signaling altered while disabled");
  a_busy_running: assert property (rdStat && runCnt inside {[1:ACCESS_CYC]} |=> apbRsp.prdata[7])
    else $error("busy low during access");
  a_busy_cleared: assert property (rdStat && runCnt == 0 |=> !apbRsp.prdata[7])
    else $error("busy high when idle");
  a_stream_latency: assert property (rxIn.bitEn |=> txOut.bitEn && txOut.frameStart == $past(rxIn.frameStart))
    else $error("bit not forwarded one cycle later");
  a_quiet_gap: assert property (!rxIn.bitEn |=> txOut == '0)
    else $error("output active without bit");
  a_full_clock: assert property (!fracSeen && rxIn.bitEn |=> txOut.sclk)
    else $error("clock missing outside fractional mode");
  a_frame_noclk: assert property (fracSeen && rxIn.bitEn && rxIn.frameStart |=> !txOut.sclk)
    else $error("clock on frame bit in fractional mode");
  a_gen_with_bit: assert property (prgdOut.genReq |-> rxIn.bitEn && enableSeen)
    else $error("generator request without enabled bit");
  a_gen_insert: assert property (prgdOut.genReq |=> txOut.data == $past(prgdGenData))
    else $error("generator bit not placed on output");
  a_extract_keeps: assert property (prgdOut.extValid |-> txOut.bitEn && prgdOut.extData == txOut.data)
    else $error("extracted bit differs from output");
  a_err_unmapped: assert property (apbReq.psel && !apbReq.penable && apbReq.paddr == 12'h100 |=> apbRsp.pslverr)
    else $error("unmapped access not flagged");
endmodule
bind rpc_payload_ctrl rpc_payload_ctrl_checker #(.ACCESS_CYC(ACCESS_CYC), .HS_DIV(HS_DIV)) rpc_payload_ctrl_checker_i (
  .mclk(mclk), .resetn(resetn), .apbReq(apbReq), .apbRsp(apbRsp), .rxIn(rxIn), .txOut(txOut),
  .prgdOut(prgdOut), .prgdGenData(prgdGenData));
`default_nettype wire

// File: test/rpc_payload_ctrl_bench.sv
// Self-checking bench for the payload control stage.
`timescale 1ns/1ps
`default_nettype none
module rpc_payload_ctrl_bench;
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] trk;
    logic [7:0] st;
    logic [7:0] din;
    logic [7:0] dout;
  } rpc_row_t;
  localparam int NROW = 10;
  rpc_row_t rows [NROW] = '{'{8'h04, 8'h00, 8'h85, 8'h3C, 8'h3C}, '{8'hC0, 8'h3C, 8'h00, 8'hA5, 8'h3C},
    '{8'h80, 8'h00, 8'h00, 8'hA5, 8'h5A}, '{8'h10, 8'h00, 8'h00, 8'hA5, 8'h25},
    '{8'h90, 8'h00, 8'h00, 8'hA5, 8'hDA}, '{8'h03, 8'h00, 8'h00, 8'hA4, 8'hA5},
    '{8'h02, 8'h00, 8'h00, 8'hA5, 8'hA4}, '{8'h08, 8'h00, 8'h00, 8'h0F, 8'hAA},
    '{8'h88, 8'h00, 8'h00, 8'h0F, 8'hAA}, '{8'h60, 8'h77, 8'h00, 8'h00, 8'h77}};
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  rpc_pkg::rpc_apb_req_t apbReq = '0;
  rpc_pkg::rpc_apb_rsp_t apbRsp;
  rpc_pkg::rpc_rx_t rxIn = '0;
  rpc_pkg::rpc_tx_t txOut;
  rpc_pkg::rpc_pattern_gen_detector_t prgdOut;
  logic prgdGenData;
  logic [15:0] extWord;
  logic [7:0] inB [24];
  logic [7:0] outD [24];
  logic [7:0] outS [24];
  int bitIdx = 0;
  int sclkCnt = 0;
  int n_errors = 0;
  int checks = 0;
  logic [31:0] rd;
  logic err;
  always #2.5 mclk = ~mclk;
  rpc_payload_ctrl #(.ACCESS_CYC(8)) rpc_payload_ctrl_i (.mclk(mclk), .resetn(resetn), .apbReq(apbReq),
    .apbRsp(apbRsp), .rxIn(rxIn), .txOut(txOut), .prgdOut(prgdOut), .prgdGenData(prgdGenData));
  rpc_pattern_gen_detector_model rpc_pattern_gen_detector_model_i (.mclk(mclk), .resetn(resetn), .prgdOut(prgdOut), .prgdGenData(prgdGenData),
    .extWord(extWord));
  // Collects each output frame into channel bytes, MSB first.
  always @(posedge mclk) begin
    if (txOut.bitEn && txOut.frameStart) begin
      bitIdx <= 0;
      sclkCnt <= 0;
    end else if (txOut.bitEn && bitIdx < 192) begin
      outD[bitIdx / 8] <= {outD[bitIdx / 8][6:0], txOut.data};
      outS[bitIdx / 8] <= {outS[bitIdx / 8][6:0], txOut.sig};
      bitIdx <= bitIdx + 1;
      sclkCnt <= sclkCnt + int'(txOut.sclk);
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    apbReq <= '{1'b1, 1'b0, wr, a, d};
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    @(posedge mclk);
    while (apbRsp.pready !== 1'b1) @(posedge mclk);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask
  // Host side polls busy before any further indirect access.
  task automatic wait_idle;
    do apb(1'b0, 12'h144, 32'h0); while (rd[7] !== 1'b0);
  endtask
  task automatic ind_write(input logic [6:0] a, input logic [7:0] d);
    apb(1'b1, 12'h14C, {24'h0, d});
    apb(1'b1, 12'h148, {25'h0, a});
    wait_idle();
  endtask
  task automatic ind_read(input logic [6:0] a);
    apb(1'b1, 12'h148, {24'h0, 1'b1, a});
    wait_idle();
    apb(1'b0, 12'h14C, 32'h0);
  endtask
  task automatic send_frame;
    int j;
    for (int i = 0; i < 193; i++) begin
      j = (i > 0) ? i - 1 : 0;
      @(posedge mclk);
      rxIn <= '{1'b1, i == 0, 1'b1, i > 0 && inB[j / 8][7 - j % 8], i > 0 && inB[j / 8][7 - j % 8]};
      @(posedge mclk);
      rxIn <= '0;
    end
    repeat (3) @(posedge mclk);
  endtask
  task automatic print_verdict;
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    print_verdict();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int r = 0; r < 24; r++) inB[r] = (r < NROW) ? rows[r].din : 8'h00;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, 12'h140 + 12'(4 * k), 32'h0);
      check({err, rd}, 33'h0);
    end
    apb(1'b0, 12'h100, 32'h0);
    check({err, rd}, 33'h100000000);
    apb(1'b1, 12'h144, 32'hFF);
    apb(1'b0, 12'h144, 32'h0);
    check(rd, 32'h0);
    for (int r = 0; r < NROW; r++) begin
      ind_write(7'(r + 1), rows[r].cfg);
      ind_write(7'(r + 25), rows[r].trk);
      ind_write(7'(r + 49), rows[r].st);
    end
    ind_read(7'h1A);
    check(rd, 32'h3C);
    ind_read(7'h31);
    check(rd, 32'h85);
    apb(1'b1, 12'h14C, 32'h11);
    apb(1'b1, 12'h148, 32'h30);
    apb(1'b1, 12'h14C, 32'h99);
    apb(1'b0, 12'h144, 32'h0);
    check(rd[7], 1'b1);
    wait_idle();
    ind_read(7'h30);
    check(rd, 32'h11);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, 12'h148, k ? 32'h49 : 32'h00);
      apb(1'b0, 12'h144, 32'h0);
      check(rd[7], 1'b0);
    end
    send_frame();
    for (int r = 0; r < 24; r++) begin
      check({outD[r], outS[r]}, {inB[r], inB[r]});
    end
    apb(1'b1, 12'h140, 32'h1);
    apb(1'b1, 12'h17C, 32'h1);
    send_frame();
    for (int r = 0; r < NROW; r++) begin
      check(outD[r], rows[r].dout);
      check(outS[r], rows[r].st[7] ? {inB[r][7:4], rows[r].st[3:0]} : inB[r]);
    end
    ind_write(7'h0B, 8'h20);
    apb(1'b1, 12'h17C, 32'h2);
    send_frame();
    check(sclkCnt, 8);
    check(extWord, 16'h0F0F);
    check(outD[8], 8'h0F);
    check(outD[10], 8'h1E);
    send_frame();
    check(outD[10], 8'h9E);
    print_verdict();
  end
endmodule
`default_nettype wire
